// File: include/hcwf_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the code word framer
// Assumes: 25 MHz core clock
// Notes: Definitions only
`ifndef HCWF_MAP_SVH
`define HCWF_MAP_SVH

// ---------------------------------------------------------------
// Clock and time figures
// ---------------------------------------------------------------
`define HCWF_CLK_MHZ 25
`define HCWF_TE_MIN_US 100
`define HCWF_RELEASE_DEBOUNCE_MS 30
`define HCWF_REPEAT_WINDOW_MS 500
`define HCWF_LONG_PREAMBLE_MS 50
`define HCWF_MS_CYCLES(ms) ((ms) * 1000 * `HCWF_CLK_MHZ)
`define HCWF_TE_CYCLES (`HCWF_TE_MIN_US * `HCWF_CLK_MHZ)

// ---------------------------------------------------------------
// Period lengths in timing elements
// ---------------------------------------------------------------
`define HCWF_PREAMBLE_TE 16'h001F
`define HCWF_HDR_PWM_TE 16'h000A
`define HCWF_HDR_MAN_TE 16'h0004
`define HCWF_DATA_PWM_TE 16'h00CF
`define HCWF_DATA_MAN_TE 16'h008E
`define HCWF_GUARD_PWM_TE 16'h002E
`define HCWF_GUARD_MAN_TE 16'h001F

// ---------------------------------------------------------------
// Code word field positions and reset values
// ---------------------------------------------------------------
`define HCWF_WORD_BITS 69
`define HCWF_CRC_SPAN 65
`define HCWF_MAN_LAST_BIT 7'h46
`define HCWF_LOW_SUPPLY_FLAG_BIT 7'h40
`define HCWF_WRAP_RESET 2'h3
`define HCWF_TALLY_MAX 2'h3
`define HCWF_COUNT_TOP 16'hFFFF
`define HCWF_LOW7_TOP 7'h7F
`define HCWF_MIN_WORDS_ONE 3'h1
`define HCWF_MIN_WORDS_FOUR 3'h4

`endif

// File: include/hcwf_pkg.sv
// Purpose: Types shared by the code word framer
// Assumes: Nothing
// Notes: Constants live in hcwf_map.svh
package hcwf_pkg;

  // ---------------------------------------------------------------
  // Word sequencer states, Gray along idle-setup-preamble-header-data-guard
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HCWF_IDLE = 3'h0,
    HCWF_SETUP = 3'h1,
    HCWF_PREAMBLE = 3'h3,
    HCWF_HEADER = 3'h2,
    HCWF_DATA = 3'h6,
    HCWF_GUARD = 3'h7
  } hcwf_state_t;

  typedef enum logic [1:0] {
    HCWF_SEED_NEVER = 2'h0,
    HCWF_SEED_LIMITED = 2'h1,
    HCWF_SEED_ALWAYS = 2'h2,
    HCWF_SEED_TWO_KEY = 2'h3
  } hcwf_seed_mode_t;

endpackage

// File: rtl/hcwf_te_timer.sv
// Purpose: Timing element divider, one tick per element
// Assumes: period of at least 2 cycles
// Notes: Clear restarts the element from its first cycle
`timescale 1ns/1ps
module hcwf_te_timer (
  input wire logic clock, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clear, // Restart the element
  input wire logic [15:0] period, // Element length in cycles
  output logic tick // Last cycle of an element
);

  logic [15:0] count;

  assign tick = !clear && (count == period - 16'h0001);

  always_ff @(posedge clock) begin
    if (reset || clear || tick) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

endmodule

// File: rtl/hcwf_crc2.sv
// Purpose: Two-bit check over the leading bits of a code word
// Assumes: Bit 0 is the first bit sent
// Notes: Purely combinational
`timescale 1ns/1ps
module hcwf_crc2 #(
  parameter int WIDTH = 65
) (
  input wire logic [WIDTH-1:0] bits, // Covered bits, first sent in bit 0
  output logic [1:0] crc // Upper bit in 1, lower in 0
);

  always_comb begin
    logic [1:0] c;
    c = 2'h0;
    for (int i = 0; i < WIDTH; i++) begin
      c = {c[0] ^ bits[i], c[0] ^ bits[i] ^ c[1]};
    end
    crc = c;
  end

endmodule

// File: rtl/hcwf_framer.sv
// Purpose: Builds and serially sends the 69-bit hopping or seed code word
// Assumes: Cipher engine outside answers cipher_start with cipher_done
// Notes: Configuration arrives as static level ports
// Behaviour
// - Preamble, header, 32 encrypted, 37 fixed, guard
// - Encrypted part: buttons, wraps, check, counter
// - Narrow serial: status, buttons, 28-bit serial
// - Wide serial: status, full 32-bit serial
// - Narrow serial top nibble carries button status
// - Release then re-press in window increments tally
// - Tally saturates at 3, holds on re-press within debounce, clears otherwise
// - Release ends after minimum; re-press restarts
// - Two-bit check over first 65 bits
// - Check recurrence from zero, bits 0..64
// - Supply sampled at onset and before bit
// - Low-supply bit one when below trip
// - Wrap flags clear on first, second wrap
// - Seed word replaces 60 bits, 69 long
// - Seed mode chooses never, limited, always
// - Coding select zero means pulse width
// - Manchester adds leading, closing one
// - Same word repeats while inputs stay
// - Period lengths per coding in elements
// - Baud select sets element, Manchester doubled
// - Blanking sends every second or fourth, every word at baud select 0
// - Long preamble stretches only first word
// - Button status includes antenna input
// - Minimum one or four complete words
`timescale 1ns/1ps
`include "hcwf_map.svh"
module hcwf_framer #(
  parameter int TE_CYCLES = `HCWF_TE_CYCLES,
  parameter int DEBOUNCE_CYCLES = `HCWF_MS_CYCLES(`HCWF_RELEASE_DEBOUNCE_MS),
  parameter int WINDOW_CYCLES = `HCWF_MS_CYCLES(`HCWF_REPEAT_WINDOW_MS),
  parameter int LONG_PRE_CYCLES = `HCWF_MS_CYCLES(`HCWF_LONG_PREAMBLE_MS)
) (
  input wire logic clock, // Core clock, 25 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [2:0] button_pins, // Button inputs, asynchronous
  input wire logic lf_antenna_input, // Antenna detector, asynchronous
  input wire logic low_supply_flag, // Low-voltage detector, asynchronous
  input wire logic line_coding_select, // 0 pulse width, 1 Manchester
  input wire logic [1:0] baud_select, // Timing element select
  input wire logic word_blanking_enable, // Blank alternate words, three of four at baud select 3, none at 0
  input wire logic long_preamble_enable, // Stretch first preamble
  input wire logic minimum_four_words_option, // At least four words
  input wire logic wide_serial_option, // Full 32-bit serial
  input wire logic seed_enable, // Seed option, upper mode bit
  input wire logic temporary_learning_enable, // Seed option, lower mode bit
  input wire logic [31:0] serial_number, // Device serial
  input wire logic [9:0] post_decrypt_check_field, // Check value
  input wire logic [59:0] seed_value, // Learning seed
  input wire logic [31:0] cipher_word, // Encrypted result
  input wire logic cipher_done, // Result valid, one cycle
  output logic cipher_start, // Plain word valid, one cycle
  output logic [31:0] plain_word, // Word to encrypt
  output logic data_out, // Coded serial data
  output logic transmitting, // Transmission in progress
  output logic [15:0] counter_value, // Synchronization counter
  output logic wrap_flag_first, // First overflow flag
  output logic wrap_flag_second, // Second overflow flag
  output logic [1:0] repeat_press_tally // Press-repeat tally
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {low_supply_flag, lf_antenna_input, button_pins};
      sync_b <= sync_a;
    end
  end

  logic [3:0] live_status;
  logic low_supply_flag_live;
  logic press;

  assign live_status = sync_b[3:0];
  assign low_supply_flag_live = sync_b[4];
  assign press = |live_status;

  // ---------------------------------------------------------------
  // Activation and press-repeat tally
  // ---------------------------------------------------------------
  hcwf_pkg::hcwf_state_t state;
  logic was_press;
  logic [3:0] active_status;
  logic [31:0] gap_cnt;
  logic start_evt;
  logic same_press;

  assign start_evt = press && (!was_press || |(live_status & ~active_status));
  assign same_press = live_status == active_status;

  always_ff @(posedge clock) begin
    if (reset) begin
      was_press <= 1'b0;
      active_status <= 4'h0;
    end else begin
      was_press <= press;
      if (start_evt) begin
        active_status <= live_status;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || press) begin
      gap_cnt <= 32'h0000_0000;
    end else if (gap_cnt <= WINDOW_CYCLES) begin
      gap_cnt <= gap_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      repeat_press_tally <= 2'h0;
    end else if (start_evt) begin
      if (!same_press || gap_cnt > WINDOW_CYCLES) begin
        repeat_press_tally <= 2'h0;
      end else if (gap_cnt >= DEBOUNCE_CYCLES && repeat_press_tally != `HCWF_TALLY_MAX) begin
        repeat_press_tally <= repeat_press_tally + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter, wrap flags and seed permission
  // ---------------------------------------------------------------
  hcwf_pkg::hcwf_seed_mode_t seed_mode;
  logic temp_seed_allowed;
  logic seed_ok;
  logic is_seed;
  logic [15:0] next_counter;
  logic next_wrap_first;
  logic next_wrap_second;

  assign seed_mode = hcwf_pkg::hcwf_seed_mode_t'({seed_enable, temporary_learning_enable});
  assign seed_ok = (seed_mode == hcwf_pkg::HCWF_SEED_ALWAYS)
    || (seed_mode == hcwf_pkg::HCWF_SEED_LIMITED && temp_seed_allowed);
  assign is_seed = seed_ok && live_status[2:0] == 3'h7;
  assign next_counter = counter_value + 16'h0001;
  assign next_wrap_first = wrap_flag_first && counter_value != `HCWF_COUNT_TOP;
  assign next_wrap_second = wrap_flag_second
    && !(counter_value == `HCWF_COUNT_TOP && !wrap_flag_first);

  always_ff @(posedge clock) begin
    if (reset) begin
      counter_value <= 16'h0000;
      wrap_flag_first <= 1'(`HCWF_WRAP_RESET);
      wrap_flag_second <= 1'(`HCWF_WRAP_RESET >> 1);
      temp_seed_allowed <= 1'b1;
    end else if (start_evt && !is_seed) begin
      counter_value <= next_counter;
      wrap_flag_first <= next_wrap_first;
      wrap_flag_second <= next_wrap_second;
      if (counter_value[6:0] == `HCWF_LOW7_TOP) begin
        temp_seed_allowed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cipher_start <= 1'b0;
      plain_word <= 32'h0000_0000;
    end else begin
      cipher_start <= start_evt && !is_seed;
      if (start_evt && !is_seed) begin
        plain_word <= {live_status, next_wrap_second, next_wrap_first,
          post_decrypt_check_field, next_counter};
      end
    end
  end

  // ---------------------------------------------------------------
  // Word assembly and check bits
  // ---------------------------------------------------------------
  logic [63:0] word_reg;
  logic seed_word;
  logic low_supply_flag_onset;
  logic low_supply_flag_tx;
  logic [1:0] crc;
  logic [68:0] tx_vec;

  hcwf_crc2 #(
    .WIDTH(`HCWF_CRC_SPAN)
  ) u_crc (
    .bits({low_supply_flag_onset, word_reg}),
    .crc(crc)
  );

  // Status bits: supply, check pair, tally
  assign tx_vec = {repeat_press_tally, crc, low_supply_flag_tx, word_reg};

  always_ff @(posedge clock) begin
    if (reset) begin
      seed_word <= 1'b0;
      low_supply_flag_onset <= 1'b0;
      word_reg <= 64'h0000_0000_0000_0000;
    end else if (start_evt) begin
      seed_word <= is_seed;
      low_supply_flag_onset <= low_supply_flag_live;
      if (is_seed) begin
        word_reg <= {live_status, seed_value};
      end
    end else if (state == hcwf_pkg::HCWF_SETUP && cipher_done) begin
      word_reg[31:0] <= cipher_word;
      if (wide_serial_option) begin
        word_reg[63:32] <= serial_number;
      end else begin
        word_reg[63:32] <= {active_status, serial_number[27:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Element timing
  // ---------------------------------------------------------------
  logic [15:0] te_period;
  logic tick;
  int rate_mult;

  always_comb begin
    unique case (baud_select)
      2'h0: rate_mult = 4;
      2'h1: rate_mult = 2;
      2'h2: rate_mult = 1;
      2'h3: rate_mult = 1;
    endcase
    te_period = 16'(TE_CYCLES * rate_mult * (line_coding_select ? 2 : 1));
  end

  hcwf_te_timer u_timer (
    .clock(clock),
    .reset(reset),
    .clear(state == hcwf_pkg::HCWF_IDLE || state == hcwf_pkg::HCWF_SETUP),
    .period(te_period),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Word sequencer
  // ---------------------------------------------------------------
  logic [15:0] idx;
  logic [6:0] bit_cnt;
  logic [1:0] phase;
  logic [1:0] slot;
  logic [2:0] words_done;
  logic first_word;
  logic [31:0] lp_cnt;
  logic lp_done;
  logic [15:0] hdr_len;
  logic [15:0] data_len;
  logic [15:0] guard_len;
  logic [2:0] min_words;
  logic [1:0] phase_last;
  logic word_end;

  assign hdr_len = line_coding_select ? `HCWF_HDR_MAN_TE : `HCWF_HDR_PWM_TE;
  assign data_len = line_coding_select ? `HCWF_DATA_MAN_TE : `HCWF_DATA_PWM_TE;
  assign guard_len = line_coding_select ? `HCWF_GUARD_MAN_TE : `HCWF_GUARD_PWM_TE;
  assign phase_last = line_coding_select ? 2'h1 : 2'h2;
  assign min_words = minimum_four_words_option ? `HCWF_MIN_WORDS_FOUR
    : `HCWF_MIN_WORDS_ONE;
  assign lp_done = !long_preamble_enable || !first_word
    || lp_cnt >= LONG_PRE_CYCLES;
  assign word_end = state == hcwf_pkg::HCWF_GUARD && tick && idx == guard_len - 16'h0001;

  always_ff @(posedge clock) begin
    if (reset) begin
      lp_cnt <= 32'h0000_0000;
    end else if (state != hcwf_pkg::HCWF_PREAMBLE) begin
      lp_cnt <= 32'h0000_0000;
    end else if (!lp_done) begin
      lp_cnt <= lp_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= hcwf_pkg::HCWF_IDLE;
      idx <= 16'h0000;
    end else if (start_evt) begin
      state <= hcwf_pkg::HCWF_SETUP;
      idx <= 16'h0000;
    end else begin
      unique case (state)
        hcwf_pkg::HCWF_IDLE: idx <= 16'h0000;
        hcwf_pkg::HCWF_SETUP: begin
          if (seed_word || cipher_done) begin
            state <= hcwf_pkg::HCWF_PREAMBLE;
          end
        end
        hcwf_pkg::HCWF_PREAMBLE: begin
          if (tick) begin
            if (idx >= `HCWF_PREAMBLE_TE - 16'h0001 && !idx[0] && lp_done) begin
              state <= hcwf_pkg::HCWF_HEADER;
              idx <= 16'h0000;
            end else begin
              idx <= idx + 16'h0001;
            end
          end
        end
        hcwf_pkg::HCWF_HEADER: begin
          if (tick) begin
            idx <= (idx == hdr_len - 16'h0001) ? 16'h0000 : idx + 16'h0001;
            if (idx == hdr_len - 16'h0001) begin
              state <= hcwf_pkg::HCWF_DATA;
            end
          end
        end
        hcwf_pkg::HCWF_DATA: begin
          if (tick) begin
            idx <= (idx == data_len - 16'h0001) ? 16'h0000 : idx + 16'h0001;
            if (idx == data_len - 16'h0001) begin
              state <= hcwf_pkg::HCWF_GUARD;
            end
          end
        end
        hcwf_pkg::HCWF_GUARD: begin
          if (tick) begin
            idx <= (idx == guard_len - 16'h0001) ? 16'h0000 : idx + 16'h0001;
          end
          if (word_end) begin
            if (!press && words_done + 3'h1 >= min_words) begin
              state <= hcwf_pkg::HCWF_IDLE;
            end else begin
              state <= hcwf_pkg::HCWF_PREAMBLE;
            end
          end
        end
        default: state <= hcwf_pkg::HCWF_IDLE;
      endcase
    end
  end

  // Word counts, blanking slot and bit position
  always_ff @(posedge clock) begin
    if (reset || start_evt) begin
      slot <= 2'h0;
      words_done <= 3'h0;
      first_word <= 1'b1;
    end else if (word_end) begin
      slot <= slot + 2'h1;
      first_word <= 1'b0;
      if (words_done != `HCWF_MIN_WORDS_FOUR) begin
        words_done <= words_done + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || state != hcwf_pkg::HCWF_DATA) begin
      bit_cnt <= 7'h00;
      phase <= 2'h0;
    end else if (tick) begin
      if (phase == phase_last) begin
        phase <= 2'h0;
        bit_cnt <= bit_cnt + 7'h01;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Line coding and output
  // ---------------------------------------------------------------
  logic [6:0] tx_index;
  logic data_bit;
  logic blank;
  logic next_data_out;

  always_comb begin
    tx_index = line_coding_select ? bit_cnt - 7'h01 : bit_cnt;
    if (line_coding_select && (bit_cnt == 7'h00 || bit_cnt == `HCWF_MAN_LAST_BIT)) begin
      data_bit = 1'b1;
    end else if (tx_index < 7'(`HCWF_WORD_BITS)) begin
      data_bit = tx_vec[tx_index];
    end else begin
      data_bit = 1'b0;
    end
  end

  // Supply sample held from the last element before the supply bit
  always_ff @(posedge clock) begin
    if (reset) begin
      low_supply_flag_tx <= 1'b0;
    end else if (state != hcwf_pkg::HCWF_DATA || tx_index < `HCWF_LOW_SUPPLY_FLAG_BIT) begin
      low_supply_flag_tx <= low_supply_flag_live;
    end
  end

  assign blank = word_blanking_enable && ((baud_select == 2'h3) ? slot != 2'h0
    : (baud_select != 2'h0 && slot[0]));

  always_comb begin
    next_data_out = 1'b0;
    unique case (state)
      hcwf_pkg::HCWF_PREAMBLE: next_data_out = !idx[0];
      hcwf_pkg::HCWF_DATA: begin
        if (line_coding_select) begin
          next_data_out = (phase == 2'h0) ? data_bit : !data_bit;
        end else begin
          next_data_out = (phase == 2'h0) || (phase == 2'h1 && !data_bit);
        end
      end
      default: next_data_out = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      data_out <= 1'b0;
      transmitting <= 1'b0;
    end else begin
      data_out <= next_data_out && !blank;
      transmitting <= state != hcwf_pkg::HCWF_IDLE;
    end
  end

endmodule

// File: tb/hcwf_framer_monitor.sv
// Purpose: Port checks of the code word framer
// Assumes: One clock, synchronous reset
// Notes: Bound to the framer below
`timescale 1ns/1ps
module hcwf_framer_monitor #(
  parameter int TE_CYCLES = 2500
) (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic [9:0] post_decrypt_check_field, // Check
  input wire logic cipher_start, // Start pulse
  input wire logic [31:0] plain_word, // Plain word
  input wire logic data_out, // Line
  input wire logic transmitting, // Busy
  input wire logic [15:0] counter_value, // Counter
  input wire logic wrap_flag_first, // Wrap one
  input wire logic wrap_flag_second, // Wrap two
  input wire logic [1:0] repeat_press_tally // Tally
);
  logic [31:0] high_run;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ---------------------------
  // Length of the high stretch
  // ---------------------------
  always_ff @(posedge clock) begin
    if (reset || !data_out) begin
      high_run <= 32'h0;
    end else begin
      high_run <= high_run + 32'h1;
    end
  end

  property p_idle_quiet;
    $rose(data_out) |-> transmitting;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line rose idle");
  property p_count_step;
    cipher_start |-> counter_value == $past(counter_value) + 16'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter step");
  property p_count_hold;
    $changed(counter_value) |-> cipher_start;
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved");
  property p_plain_fields;
    cipher_start |-> plain_word[15:0] == counter_value
      && plain_word[25:16] == post_decrypt_check_field;
  endproperty
  a_plain_fields: assert property (p_plain_fields) else $error("plain fields");
  property p_wrap_one;
    $fell(wrap_flag_first) |-> counter_value == 16'h0 && wrap_flag_second;
  endproperty
  a_wrap_one: assert property (p_wrap_one) else $error("wrap one");
  property p_wrap_two;
    $fell(wrap_flag_second) |-> counter_value == 16'h0 && !$past(wrap_flag_first);
  endproperty
  a_wrap_two: assert property (p_wrap_two) else $error("wrap two");
  property p_tally_step;
    $changed(repeat_press_tally) |-> repeat_press_tally == 2'h0
      || repeat_press_tally == $past(repeat_press_tally) + 2'h1;
  endproperty
  a_tally_step: assert property (p_tally_step) else $error("tally step");
  property p_high_run;
    high_run <= 16 * TE_CYCLES;
  endproperty
  a_high_run: assert property (p_high_run) else $error("line high too long");
endmodule

bind hcwf_framer hcwf_framer_monitor #(.TE_CYCLES(TE_CYCLES)) u_monitor (
  .clock, .reset, .post_decrypt_check_field, .cipher_start, .plain_word, .data_out,
  .transmitting, .counter_value, .wrap_flag_first, .wrap_flag_second, .repeat_press_tally
);

// File: tb/hcwf_partner.sv
// Purpose: Cipher engine and RF receiver beside the framer
// Assumes: te holds the element length in cycles
// Notes: A word starts at a rise after three low elements
`timescale 1ns/1ps
module hcwf_partner #(
  parameter logic [31:0] MASK = 32'h0
) (
  input wire logic clock, // Clock
  input wire logic slow, // Late answer
  input wire logic man, // Manchester
  input wire logic [31:0] te, // Element cycles
  input wire logic cipher_start, // Start pulse
  input wire logic [31:0] plain_word, // Plain word
  output logic cipher_done, // Result pulse
  output logic [31:0] cipher_word, // Result
  input wire logic data_out, // Line
  output logic [68:0] rx_word, // Last word
  output logic [31:0] rx_count // Words heard
);
  logic [31:0] held, wait_left, low_run, cyc, k, pos;
  logic prev;

  assign pos = man ? te * (2 * k + 2) + te / 2 : te * (3 * k + 1) + te / 2;

  initial begin
    cipher_done = 1'b0;
    cipher_word = 32'h0;
    {wait_left, low_run, cyc, rx_count} = 128'h0;
    k = 32'h45;
    prev = 1'b0;
  end

  // Result only valid with the pulse, noise otherwise
  always @(posedge clock) begin
    cipher_done <= 1'b0;
    cipher_word <= ~cipher_word;
    if (cipher_start) begin
      held <= plain_word ^ MASK;
      wait_left <= slow ? 32'h28 : 32'h1;
    end else if (wait_left == 32'h1) begin
      cipher_done <= 1'b1;
      cipher_word <= held;
      wait_left <= 32'h0;
    end else if (wait_left != 32'h0) begin
      wait_left <= wait_left - 32'h1;
    end
  end

  // Sample each bit in the middle of its data element
  always @(posedge clock) begin
    prev <= data_out;
    low_run <= data_out ? 32'h0 : low_run + 32'h1;
    cyc <= cyc + 32'h1;
    if (data_out && !prev && low_run >= 3 * te) begin
      cyc <= 32'h1;
      k <= 32'h0;
    end else if (k < 32'h45 && cyc == pos) begin
      rx_word[k] <= man ? data_out : !data_out;
      k <= k + 32'h1;
      rx_count <= rx_count + ((k == 32'h44) ? 32'h1 : 32'h0);
    end
  end
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench of the code word framer
// Assumes: Shortened timing parameters
// Notes: Words are judged as the receiver decodes them
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] MASK = 32'h5A3C96E1;
  logic clock = 1'b0, reset = 1'b1, slow = 1'b0;
  logic [2:0] button_pins = 3'h0;
  logic lf_antenna_input = 1'b0, low_supply_flag = 1'b0, line_coding_select = 1'b0;
  logic [1:0] baud_select = 2'h2;
  logic word_blanking_enable = 1'b0, long_preamble_enable = 1'b0;
  logic minimum_four_words_option = 1'b0, wide_serial_option = 1'b0;
  logic seed_enable = 1'b0, temporary_learning_enable = 1'b0;
  logic [31:0] serial_number = 32'hC3A51F27, te = 32'h4;
  logic [9:0] post_decrypt_check_field = 10'h2B5;
  logic [59:0] seed_value = 60'h9E3779B97F4A7C1;
  logic cipher_done, cipher_start, data_out, transmitting;
  logic wrap_flag_first, wrap_flag_second;
  logic [31:0] cipher_word, plain_word, rx_count;
  logic [15:0] counter_value, cnt = 16'h0;
  logic [1:0] repeat_press_tally;
  logic [68:0] rx_word, last;
  int errors = 0, num_checks = 0, base, span;

  hcwf_framer #(.TE_CYCLES(4), .DEBOUNCE_CYCLES(20), .WINDOW_CYCLES(3000),
    .LONG_PRE_CYCLES(400)) uut (
    .clock, .reset, .button_pins, .lf_antenna_input, .low_supply_flag, .line_coding_select,
    .baud_select, .word_blanking_enable, .long_preamble_enable, .minimum_four_words_option,
    .wide_serial_option, .seed_enable, .temporary_learning_enable, .serial_number,
    .post_decrypt_check_field, .seed_value, .cipher_word, .cipher_done, .cipher_start,
    .plain_word, .data_out, .transmitting, .counter_value, .wrap_flag_first,
    .wrap_flag_second, .repeat_press_tally
  );
  hcwf_partner #(.MASK(MASK)) partner (
    .clock, .slow, .man(line_coding_select), .te, .cipher_start, .plain_word,
    .cipher_done, .cipher_word, .data_out, .rx_word, .rx_count
  );

  always #20 clock = ~clock;

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [68:0] got, input logic [68:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic hang(input logic stuck);
    if (stuck) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic wait_rx();
    int b;
    int n;
    b = rx_count;
    for (n = 0; n < 40000 && rx_count == b; n++) tick(1);
    hang(rx_count == b);
  endtask

  task automatic stop();
    int n;
    {button_pins, lf_antenna_input} = 4'h0;
    for (n = 0; n < 40000 && transmitting !== 1'b0; n++) tick(1);
    hang(transmitting !== 1'b0);
  endtask

  // Check bits over the first 65, then tally, LSB first
  function automatic logic [68:0] word(input logic [31:0] c, input logic [31:0] f,
    input logic [1:0] t);
    logic [64:0] d;
    logic [1:0] r;
    d = {low_supply_flag, f, c};
    r = 2'h0;
    for (int i = 0; i < 65; i++) r = {r[0] ^ d[i], r[0] ^ d[i] ^ r[1]};
    return {t, r, d};
  endfunction

  task automatic go(input logic [2:0] b, input logic [1:0] t, input logic sd);
    logic [3:0] s;
    s = {lf_antenna_input, b};
    button_pins = b;
    if (sd) begin
      last = word(seed_value[31:0], {s, seed_value[59:32]}, t);
    end else begin
      cnt = cnt + 16'h1;
      last = word({s, 2'h3, post_decrypt_check_field, cnt} ^ MASK,
        wide_serial_option ? serial_number : {s, serial_number[27:0]}, t);
    end
    wait_rx();
    check(rx_word, last);
  endtask

  initial begin
    tick(8);
    reset = 1'b0;
    go(3'h1, 2'h0, 1'b0);
    wait_rx();
    check(rx_word, last);
    stop();
    for (int n = 1; n < 5; n++) begin
      tick(30);
      go(3'h1, (n > 3) ? 2'h3 : 2'(n), 1'b0);
      stop();
    end
    wide_serial_option = 1'b1;
    low_supply_flag = 1'b1;
    lf_antenna_input = 1'b1;
    slow = 1'b1;
    go(3'h2, 2'h0, 1'b0);
    stop();
    tick(3100);
    lf_antenna_input = 1'b1;
    go(3'h2, 2'h0, 1'b0);
    stop();
    line_coding_select = 1'b1;
    te = 32'h8;
    go(3'h4, 2'h0, 1'b0);
    stop();
    line_coding_select = 1'b0;
    te = 32'h4;
    for (int m = 0; m < 4; m++) begin
      {seed_enable, temporary_learning_enable} = 2'(m);
      tick(3100);
      go(3'h7, 2'h0, m == 1 || m == 2);
      stop();
    end
    check(69'(counter_value), 69'(cnt));
    word_blanking_enable = 1'b1;
    for (int r = 0; r < 4; r++) begin
      baud_select = 2'(r);
      te = (r == 0) ? 32'h10 : (r == 1) ? 32'h8 : 32'h4;
      base = rx_count;
      button_pins = 3'h1;
      cnt = cnt + 16'h1;
      tick(4 * 294 * te + 10);
      check(69'(rx_count - base), (r == 0) ? 69'h4 : (r == 3) ? 69'h1 : 69'h2);
      stop();
    end
    word_blanking_enable = 1'b0;
    baud_select = 2'h2;
    te = 32'h4;
    for (int f = 0; f < 2; f++) begin
      long_preamble_enable = 1'b1;
      minimum_four_words_option = 1'(f);
      base = rx_count;
      span = int'($time);
      button_pins = 3'h1;
      cnt = cnt + 16'h1;
      tick(10);
      stop();
      check(69'(rx_count - base), (f == 1) ? 69'h4 : 69'h1);
      // Span in steps of 200 cycles: only the first preamble runs 101 elements
      check(69'((int'($time) - span) / 8000), 69'(f ? 25 : 7));
    end
    check(69'(counter_value), 69'(cnt));
    finish_test();
  end
endmodule
